// File: rtl/fcsf_pkg.sv
// Package with register map, field positions and encodings for the status flag block.
package fcsf_pkg;
    // Register byte addresses on the APB.
    localparam logic [7:0] ADDR_CMD_END      = 8'h00;
    localparam logic [7:0] ADDR_XFER_ERR     = 8'h04;
    localparam logic [7:0] ADDR_MEDIA_MARK   = 8'h08;
    localparam logic [7:0] ADDR_CONTROL      = 8'h0C;
    localparam logic [7:0] ADDR_DRIVE_STATE  = 8'h10;
    localparam logic [7:0] ADDR_RESULT_READY = 8'h14;

    // Termination class codes in bits 7:6 of the first status byte.
    localparam logic [1:0] TC_NORMAL  = 2'h0;
    localparam logic [1:0] TC_ABNORM  = 2'h1;
    localparam logic [1:0] TC_INVALID = 2'h2;
    localparam logic [1:0] TC_READY   = 2'h3;

    // Field positions in the first status byte.
    localparam int B0_TC_LO = 6;
    localparam int B0_SEEK  = 5;
    localparam int B0_EQUIP = 4;
    localparam int B0_NRDY  = 3;
    localparam int B0_HEAD  = 2;
    localparam int B0_UHI   = 1;
    localparam int B0_ULO   = 0;

    // Field positions in the second status byte.
    localparam int B1_EOC   = 7;
    localparam int B1_DERR  = 5;
    localparam int B1_OVR   = 4;
    localparam int B1_NODAT = 2;
    localparam int B1_NWR   = 1;
    localparam int B1_MAM   = 0;

    // Field positions in the third status byte.
    localparam int B2_CM    = 6;
    localparam int B2_DCRC  = 5;
    localparam int B2_WCYL  = 4;
    localparam int B2_SHIT  = 3;
    localparam int B2_SNOT  = 2;
    localparam int B2_BCYL  = 1;
    localparam int B2_MDM   = 0;

    // Control register fields.
    localparam int CTL_START = 0;
    localparam int CTL_ACK   = 1;

    // Recalibrate step limit and index pulse limit for ID search.
    localparam logic [6:0] RECAL_STEPS   = 7'h4D;
    localparam logic [1:0] INDEX_LIMIT   = 2'h2;
    localparam logic [7:0] BAD_CYL_VALUE = 8'hFF;

    // Command kinds as seen by the status logic.
    typedef enum logic [2:0] {
        FCSF_CMD_READ,
        FCSF_CMD_WRITE,
        FCSF_CMD_FORMAT,
        FCSF_CMD_SCAN,
        FCSF_CMD_READ_ID,
        FCSF_CMD_READ_TRACK,
        FCSF_CMD_SEEK,
        FCSF_CMD_RECAL
    } fcsf_cmd_t;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : fcsf_pkg

// File: rtl/fcsf_step_monitor.sv
// Recalibrate step counter and index pulse window for the status flag block.
`timescale 1ns/1ps
`default_nettype none
module fcsf_step_monitor
    import fcsf_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       recal_active,
    input  wire logic       step_pulse,
    input  wire logic       track_zero,
    input  wire logic       id_search,
    input  wire logic       id_mark_seen,
    input  wire logic       index_pulse,
    output logic            recal_fail,
    output logic            id_missing
);
    logic [6:0] step_count;
    logic [1:0] index_count;

    // Counts step pulses of a recalibrate; a full count with no track zero is a failure.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            step_count <= '0;
        else if (clear || !recal_active || track_zero)
            step_count <= '0;
        else if (step_pulse && step_count != RECAL_STEPS)
            step_count <= step_count + 7'h01;
    end

    // Failure is a level held until clear so the parent may sample it in any later cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            recal_fail <= 1'b0;
        else if (clear)
            recal_fail <= 1'b0;
        else if (recal_active && !track_zero && step_count == RECAL_STEPS)
            recal_fail <= 1'b1;
    end

    // Counts index pulses while an ID mark is looked for; a found mark restarts the window.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            index_count <= '0;
        else if (clear || !id_search || id_mark_seen)
            index_count <= '0;
        else if (index_pulse && index_count != INDEX_LIMIT)
            index_count <= index_count + 2'h1;
    end

    // Two index pulses with no ID mark reports the mark missing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            id_missing <= 1'b0;
        else if (clear)
            id_missing <= 1'b0;
        else if (id_search && index_count == INDEX_LIMIT)
            id_missing <= 1'b1;
    end
endmodule // fcsf_step_monitor
`default_nettype wire

// File: rtl/fcsf_status_flags.sv
// Top of the floppy controller status flag block with its APB register file.
//
// Summary of operation
// - Normal end 00, started but failed 01.
// - Invalid command never started reports 10.
// - Ready change during command reports 11.
// - Seek completion sets seek finished flag.
// - Drive fault or 77 steps sets equipment check.
// - Not ready or side 1 single-sided sets flag.
// - Head and unit select captured at end.
// - Sector beyond cylinder end sets end flag.
// - Unused bits of bytes two, three read zero.
// - ID or data CRC failure sets data error.
// - Late host byte service sets overrun flag.
// - Sector, ID or start sector missing: no data.
// - Write protect on writes sets not writable.
// - Missing data or ID mark sets address flag.
// - Deleted mark on read or scan: control mark.
// - Data field CRC failure sets third byte bit.
// - Cylinder mismatch sets wrong, FF sets bad.
// - Scan equal hit and scan not satisfied.
// - No data mark on read sets bit zero.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fcsf_status_flags
    import fcsf_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire fcsf_pkg::fcsf_cmd_t  cmd_kind,
    input  wire logic                 cmd_invalid,
    input  wire logic                 cmd_done,
    input  wire logic                 head_select,
    input  wire logic [1:0]           unit_select,
    input  wire logic                 drive_fault,
    input  wire logic                 drive_ready,
    input  wire logic                 drive_two_side,
    input  wire logic                 track_zero,
    input  wire logic                 write_protect,
    input  wire logic                 index_pulse,
    input  wire logic                 step_pulse,
    input  wire logic                 seek_done,
    input  wire logic                 sector_past_end,
    input  wire logic                 id_crc_fail,
    input  wire logic                 data_crc_fail,
    input  wire logic                 byte_late,
    input  wire logic                 sector_not_found,
    input  wire logic                 id_mark_seen,
    input  wire logic                 data_mark_missing,
    input  wire logic                 deleted_mark_seen,
    input  wire logic                 cylinder_valid,
    input  wire logic [7:0]           cylinder_read,
    input  wire logic [7:0]           cylinder_requested,
    input  wire logic                 scan_equal,
    input  wire logic                 scan_exhausted,
    output logic                      cmd_busy,
    output logic                      result_ready
);
    typedef enum logic [1:0] {FCSF_IDLE, FCSF_RUN, FCSF_RESULT} fcsf_state_t;

    fcsf_state_t state;
    logic [7:0]  cmd_end_status;
    logic [7:0]  transfer_error_status;
    logic [7:0]  media_mark_status;
    logic [7:0]  acc1;
    logic [7:0]  acc2;
    logic        acc_seek;
    logic        acc_equip;
    logic        acc_nrdy;
    logic        acc_err;
    logic        ready_changed;
    logic        ready_at_start;
    fcsf_cmd_t   run_kind;
    logic        recal_fail;
    logic        id_missing;
    logic        mon_clear;
    logic        apb_wr;
    logic        apb_rd;
    logic        start_req;
    logic        ack_req;

    // Read and write kinds that need a ready drive and a present side.
    function automatic logic is_rw(input fcsf_cmd_t k);
        return k == FCSF_CMD_READ || k == FCSF_CMD_WRITE || k == FCSF_CMD_SCAN
            || k == FCSF_CMD_FORMAT || k == FCSF_CMD_READ_ID || k == FCSF_CMD_READ_TRACK;
    endfunction

    // Kinds that read data fields from the medium.
    function automatic logic is_read(input fcsf_cmd_t k);
        return k == FCSF_CMD_READ || k == FCSF_CMD_SCAN;
    endfunction

    assign apb_wr    = psel && penable && pwrite;
    assign apb_rd    = psel && penable && !pwrite;
    assign start_req = apb_wr && paddr == ADDR_CONTROL && pwdata[CTL_START];
    assign ack_req   = apb_wr && paddr == ADDR_CONTROL && pwdata[CTL_ACK];
    assign mon_clear = state != FCSF_RUN;

    fcsf_step_monitor u_mon (
        .pclk         (pclk),
        .presetn      (presetn),
        .clear        (mon_clear),
        .recal_active (run_kind == FCSF_CMD_RECAL && state == FCSF_RUN),
        .step_pulse   (step_pulse),
        .track_zero   (track_zero),
        .id_search    (is_rw(run_kind) && state == FCSF_RUN),
        .id_mark_seen (id_mark_seen),
        .index_pulse  (index_pulse),
        .recal_fail   (recal_fail),
        .id_missing   (id_missing)
    );

    // Command sequencing; an invalid command goes straight to the result phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= FCSF_IDLE;
        else
            case (state)
                FCSF_IDLE:
                    if (start_req)
                        state <= cmd_invalid ? FCSF_RESULT : FCSF_RUN;
                FCSF_RUN:
                    if (cmd_done || ready_changed)
                        state <= FCSF_RESULT;
                FCSF_RESULT:
                    if (ack_req)
                        state <= FCSF_IDLE;
                default:
                    state <= FCSF_IDLE;
            endcase
    end

    // Command kind and ready level are latched at start.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_kind       <= FCSF_CMD_READ;
            ready_at_start <= 1'b0;
        end
        else if (state == FCSF_IDLE && start_req)
        begin
            run_kind       <= cmd_kind;
            ready_at_start <= drive_ready;
        end
    end

    // Any ready edge during a run ends the command abnormally.
    assign ready_changed = drive_ready != ready_at_start;

    // Flags accumulate during the run; set wins, cleared only at the next start.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc1      <= '0;
            acc2      <= '0;
            acc_seek  <= 1'b0;
            acc_equip <= 1'b0;
            acc_nrdy  <= 1'b0;
        end
        else if (state == FCSF_IDLE && start_req)
        begin
            acc1      <= '0;
            acc2      <= '0;
            acc_seek  <= 1'b0;
            acc_equip <= 1'b0;
            acc_nrdy  <= is_rw(cmd_kind) && !cmd_invalid
                         && (!drive_ready || (head_select && !drive_two_side));
        end
        else if (state == FCSF_RUN)
        begin
            if (seek_done && (run_kind == FCSF_CMD_SEEK || run_kind == FCSF_CMD_RECAL))
                acc_seek <= 1'b1;
            if (drive_fault || recal_fail)
                acc_equip <= 1'b1;
            if (sector_past_end)
                acc1[B1_EOC] <= 1'b1;
            if (id_crc_fail || data_crc_fail)
                acc1[B1_DERR] <= 1'b1;
            if (byte_late)
                acc1[B1_OVR] <= 1'b1;
            if (sector_not_found || (run_kind == FCSF_CMD_READ_ID && id_crc_fail))
                acc1[B1_NODAT] <= 1'b1;
            if (write_protect && (run_kind == FCSF_CMD_WRITE || run_kind == FCSF_CMD_FORMAT))
                acc1[B1_NWR] <= 1'b1;
            if ((data_mark_missing && is_read(run_kind)) || id_missing)
                acc1[B1_MAM] <= 1'b1;
            if (data_mark_missing && is_read(run_kind))
                acc2[B2_MDM] <= 1'b1;
            if (deleted_mark_seen && is_read(run_kind))
                acc2[B2_CM] <= 1'b1;
            if (data_crc_fail)
                acc2[B2_DCRC] <= 1'b1;
            if (cylinder_valid && cylinder_read != cylinder_requested)
            begin
                if (cylinder_read == BAD_CYL_VALUE)
                    acc2[B2_BCYL] <= 1'b1;
                else
                    acc2[B2_WCYL] <= 1'b1;
            end
            if (run_kind == FCSF_CMD_SCAN && scan_equal)
                acc2[B2_SHIT] <= 1'b1;
            if (run_kind == FCSF_CMD_SCAN && scan_exhausted)
                acc2[B2_SNOT] <= 1'b1;
        end
    end

    // Any error flag means the command started but did not finish properly.
    assign acc_err = acc_equip || acc_nrdy || (|acc1) || acc2[B2_DCRC] || acc2[B2_WCYL]
                  || acc2[B2_BCYL] || acc2[B2_SNOT] || acc2[B2_MDM];

    // Result bytes are captured once as the command ends and held until the next command ends or an invalid command starts.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_end_status        <= '0;
            transfer_error_status <= '0;
            media_mark_status     <= '0;
        end
        else if (state == FCSF_IDLE && start_req && cmd_invalid)
        begin
            cmd_end_status        <= {TC_INVALID, 6'h00};
            transfer_error_status <= '0;
            media_mark_status     <= '0;
        end
        else if (state == FCSF_RUN && (cmd_done || ready_changed))
        begin
            cmd_end_status[B0_TC_LO+1:B0_TC_LO] <= ready_changed ? TC_READY
                                                 : (acc_err ? TC_ABNORM : TC_NORMAL);
            cmd_end_status[B0_SEEK]  <= acc_seek;
            cmd_end_status[B0_EQUIP] <= acc_equip;
            cmd_end_status[B0_NRDY]  <= acc_nrdy;
            cmd_end_status[B0_HEAD]  <= head_select;
            cmd_end_status[B0_UHI]   <= unit_select[1];
            cmd_end_status[B0_ULO]   <= unit_select[0];
            transfer_error_status    <= acc1 & 8'hB7;
            media_mark_status        <= acc2 & 8'h7F;
        end
    end

    // Status outputs toward the command sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_busy     <= 1'b0;
            result_ready <= 1'b0;
        end
        else
        begin
            cmd_busy     <= state == FCSF_RUN;
            result_ready <= state == FCSF_RESULT;
        end
    end

    // APB answers in the access cycle with no wait state; the reply is registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= RDATA_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= RDATA_ZERO;
            if (psel && !penable)
                case (paddr)
                    ADDR_CMD_END:      prdata <= {24'h00_0000, cmd_end_status};
                    ADDR_XFER_ERR:     prdata <= {24'h00_0000, transfer_error_status};
                    ADDR_MEDIA_MARK:   prdata <= {24'h00_0000, media_mark_status};
                    ADDR_CONTROL:      prdata <= RDATA_ZERO;
                    ADDR_DRIVE_STATE:  prdata <= {24'h00_0000, drive_fault, write_protect,
                                         drive_ready, track_zero, drive_two_side,
                                         head_select, unit_select};
                    ADDR_RESULT_READY: prdata <= {30'h0000_0000, state == FCSF_RUN,
                                         state == FCSF_RESULT};
                    default:           pslverr <= 1'b1;
                endcase
        end
    end

    logic unused_rd;
    assign unused_rd = apb_rd;
endmodule // fcsf_status_flags
`default_nettype wire

// File: test/fcsf_drive_model.sv
// Behavioural floppy drive: index pulses and a head that reaches track zero after HOME steps.
`timescale 1ns/1ps
`default_nettype none
module fcsf_drive_model #(
    parameter int IDX_GAP = 20,
    parameter int HOME    = 100
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic spin,
    input  wire logic step_pulse,
    output logic      index_pulse,
    output logic      track_zero
);
    logic [7:0] steps;
    logic [7:0] gap;

    // Steps saturate so that a long recalibrate cannot wrap back below HOME and lose track zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            steps <= 8'h00;
        else if (step_pulse && steps != 8'hFF)
            steps <= steps + 8'h01;
    end
    assign track_zero = (int'(steps) >= HOME);

    // The index hole passes once per revolution, only while the disk spins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap <= 8'h00;
        else if (!spin || int'(gap) == IDX_GAP - 1)
            gap <= 8'h00;
        else
            gap <= gap + 8'h01;
    end
    assign index_pulse = spin && (int'(gap) == IDX_GAP - 1);
endmodule // fcsf_drive_model
`default_nettype wire

// File: test/fcsf_status_flags_assertions.sv
// Checker with timing relations of the status flag block at its ports.
`timescale 1ns/1ps
`default_nettype none
module fcsf_status_flags_assertions
    import fcsf_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cmd_invalid,
    input wire logic        cmd_done,
    input wire logic        drive_ready,
    input wire logic        cmd_busy,
    input wire logic        result_ready
);
    logic ctl_wr;
    logic rd_done;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decoded control writes and completing reads.
    assign ctl_wr  = psel && penable && pwrite && paddr == ADDR_CONTROL;
    assign rd_done = pready && !pwrite;

    a_xfer_zero_bits: assert property (rd_done && paddr == ADDR_XFER_ERR |->
        prdata[6] == 1'b0 && prdata[3] == 1'b0 && prdata[31:8] == 24'h00_0000)
        else $error("unused transfer status bits not zero");
    a_media_zero_bit: assert property (rd_done && paddr == ADDR_MEDIA_MARK |->
        prdata[7] == 1'b0) else $error("unused media status bit not zero");
    a_invalid_ends: assert property (ctl_wr && pwdata[CTL_START] && cmd_invalid &&
        !cmd_busy && !result_ready |-> ##[1:3] result_ready && !cmd_busy)
        else $error("invalid command did not end at once");
    a_start_runs: assert property (ctl_wr && pwdata[CTL_START] && !cmd_invalid &&
        !cmd_busy && !result_ready |-> ##[1:3] (cmd_busy || result_ready))
        else $error("command start not taken");
    a_done_result: assert property (cmd_busy && cmd_done |-> ##[1:3] result_ready)
        else $error("no result phase after command end");
    a_ready_abort: assert property (cmd_busy && $changed(drive_ready) |->
        ##[1:3] result_ready) else $error("ready change did not end command");
    a_result_holds: assert property (result_ready && !ctl_wr && !$past(ctl_wr) |=>
        result_ready) else $error("result phase left without acknowledge");
    a_phase_apart: assert property (!(cmd_busy && result_ready))
        else $error("busy and result phase together");
    a_err_with_ready: assert property (pslverr |-> pready && prdata == RDATA_ZERO)
        else $error("slave error outside a completing access");

    c_invalid: cover property (ctl_wr && pwdata[CTL_START] && cmd_invalid);
    c_ready_abort: cover property (cmd_busy && $changed(drive_ready));
    c_slave_err: cover property (pslverr);
endmodule // fcsf_status_flags_assertions

bind fcsf_status_flags fcsf_status_flags_assertions i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_invalid(cmd_invalid),
    .cmd_done(cmd_done), .drive_ready(drive_ready), .cmd_busy(cmd_busy),
    .result_ready(result_ready));
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the status flag block with an APB master and a drive model.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fcsf_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, cyl_rd = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_002E;
    logic        pready, pslverr, cmd_busy, result_ready, index_pulse, track_zero;
    logic        cmd_invalid = 1'h0, cmd_done = 1'h0, head_select = 1'h0, step_pulse = 1'h0;
    logic        drive_fault = 1'h0, drive_ready = 1'h1, drive_two_side = 1'h1;
    logic        write_protect = 1'h0, spin = 1'h0;
    logic [1:0]  unit_select = 2'h0;
    logic [11:0] ev = 12'h000;
    logic [33:0] note;
    fcsf_cmd_t   cmd_kind = FCSF_CMD_READ;
    logic [33:0] exp_q[$];
    int          n_fail = 0, n_tests = 0;

    always #50 pclk = ~pclk;

    fcsf_drive_model i_fcsf_drive_model (.pclk(pclk), .presetn(presetn), .spin(spin),
        .step_pulse(step_pulse), .index_pulse(index_pulse), .track_zero(track_zero));
    fcsf_status_flags i_fcsf_status_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_kind(cmd_kind), .cmd_invalid(cmd_invalid),
        .cmd_done(cmd_done), .head_select(head_select), .unit_select(unit_select),
        .drive_fault(drive_fault), .drive_ready(drive_ready), .drive_two_side(drive_two_side),
        .track_zero(track_zero), .write_protect(write_protect), .index_pulse(index_pulse),
        .step_pulse(step_pulse), .seek_done(ev[0]), .sector_past_end(ev[1]),
        .id_crc_fail(ev[2]), .data_crc_fail(ev[3]), .byte_late(ev[4]),
        .sector_not_found(ev[5]), .id_mark_seen(ev[6]), .data_mark_missing(ev[7]),
        .deleted_mark_seen(ev[8]), .scan_equal(ev[9]), .scan_exhausted(ev[10]),
        .cylinder_valid(ev[11]), .cylinder_read(cyl_rd), .cylinder_requested(8'h05),
        .cmd_busy(cmd_busy), .result_ready(result_ready));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic lim(input bit ok);
        if (!ok)
        begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the expected answer is noted before the request goes out.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        int n;
        exp_q.push_back({!w, e, er});
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 9);
        psel    <= 1'h0;
        penable <= 1'h0;
        lim(n < 9);
    endtask

    // Answers are compared at the edge that completes the access.
    always @(posedge pclk)
    begin
        if (pready === 1'h1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[33])
                cmp("prdata", note[32:1], prdata);
            cmp("pslverr", {31'h0, note[0]}, {31'h0, pslverr});
        end
    end

    task automatic go(input fcsf_cmd_t k, input logic inv);
        cmd_kind    <= k;
        cmd_invalid <= inv;
        {head_select, unit_select} <= 3'(xs());
        apb(1'h1, ADDR_CONTROL, 32'h0000_0001, 32'h0, 1'h0);
    endtask

    // End the run, wait for the result phase, read the three bytes and acknowledge.
    task automatic fin(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        int n;
        @(posedge pclk);
        cmd_done <= 1'h1;
        @(posedge pclk);
        cmd_done <= 1'h0;
        n = 0;
        while (result_ready !== 1'h1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        lim(n < 40);
        apb(1'h0, ADDR_CMD_END, 32'h0, {24'h0, b0}, 1'h0);
        apb(1'h0, ADDR_XFER_ERR, 32'h0, {24'h0, b1}, 1'h0);
        apb(1'h0, ADDR_MEDIA_MARK, 32'h0, {24'h0, b2}, 1'h0);
        apb(1'h1, ADDR_CONTROL, 32'h0000_0002, 32'h0, 1'h0);
    endtask

    function automatic logic [7:0] hu();
        return {5'h00, head_select, unit_select};
    endfunction

    task automatic ev_case(input fcsf_cmd_t k, input int i, input logic [7:0] c,
                           input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        go(k, 1'h0);
        cyl_rd <= c;
        @(posedge pclk);
        ev[i] <= 1'h1;
        @(posedge pclk);
        ev <= 12'h000;
        fin(b0 | hu(), b1, b2);
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        go(FCSF_CMD_SEEK, 1'h0);
        fin(hu(), 8'h00, 8'h00);
        go(FCSF_CMD_READ, 1'h0);
        fin(hu(), 8'h00, 8'h00);
        go(FCSF_CMD_WRITE, 1'h1);
        fin(8'h80, 8'h00, 8'h00);
        ev_case(FCSF_CMD_SEEK, 0, 8'h05, 8'h20, 8'h00, 8'h00);
        ev_case(FCSF_CMD_READ, 1, 8'h05, 8'h40, 8'h80, 8'h00);
        ev_case(FCSF_CMD_READ, 2, 8'h05, 8'h40, 8'h20, 8'h00);
        ev_case(FCSF_CMD_READ, 3, 8'h05, 8'h40, 8'h20, 8'h20);
        ev_case(FCSF_CMD_READ, 4, 8'h05, 8'h40, 8'h10, 8'h00);
        ev_case(FCSF_CMD_READ, 5, 8'h05, 8'h40, 8'h04, 8'h00);
        ev_case(FCSF_CMD_READ, 7, 8'h05, 8'h40, 8'h01, 8'h01);
        ev_case(FCSF_CMD_READ, 8, 8'h05, 8'h00, 8'h00, 8'h40);
        ev_case(FCSF_CMD_SCAN, 9, 8'h05, 8'h00, 8'h00, 8'h08);
        ev_case(FCSF_CMD_SCAN, 10, 8'h05, 8'h40, 8'h00, 8'h04);
        ev_case(FCSF_CMD_READ, 11, 8'h07, 8'h40, 8'h00, 8'h10);
        ev_case(FCSF_CMD_READ, 11, 8'hFF, 8'h40, 8'h00, 8'h02);
        @(posedge pclk);
        ev[4] <= 1'h1;
        @(posedge pclk);
        ev <= 12'h000;
        apb(1'h0, ADDR_XFER_ERR, 32'h0, 32'h0, 1'h0);
        apb(1'h0, 8'h18, 32'h0, 32'h0, 1'h1);
        apb(1'h1, 8'h1C, 32'h0000_00FF, 32'h0, 1'h1);
        write_protect <= 1'h1;
        go(FCSF_CMD_WRITE, 1'h0);
        fin(8'h40 | hu(), 8'h02, 8'h00);
        write_protect <= 1'h0;
        drive_ready <= 1'h0;
        go(FCSF_CMD_READ, 1'h0);
        fin(8'h48 | hu(), 8'h00, 8'h00);
        drive_ready <= 1'h1;
        drive_two_side <= 1'h0;
        repeat (3)
        begin
            go(FCSF_CMD_WRITE, 1'h0);
            fin(head_select ? (8'h48 | hu()) : hu(), 8'h00, 8'h00);
        end
        drive_two_side <= 1'h1;
        go(FCSF_CMD_READ, 1'h0);
        @(posedge pclk);
        drive_ready <= 1'h0;
        fin(8'hC0 | hu(), 8'h00, 8'h00);
        drive_ready <= 1'h1;
        go(FCSF_CMD_READ, 1'h0);
        drive_fault <= 1'h1;
        fin(8'h50 | hu(), 8'h00, 8'h00);
        drive_fault <= 1'h0;
        go(FCSF_CMD_RECAL, 1'h0);
        repeat (77)
        begin
            @(posedge pclk);
            step_pulse <= 1'h1;
            @(posedge pclk);
            step_pulse <= 1'h0;
        end
        repeat (5) @(posedge pclk);
        fin(8'h50 | hu(), 8'h00, 8'h00);
        spin <= 1'h1;
        go(FCSF_CMD_READ, 1'h0);
        repeat (70) @(posedge pclk);
        fin(8'h40 | hu(), 8'h01, 8'h00);
        conclude();
    end
endmodule // tb
`default_nettype wire
